// >>> hw/sew_pkg.sv
// Constants, types and check bits of the array write block
package sew_pkg;
    // Array geometry
    localparam int SEW_ARRAY_BYTES = 32768;
    localparam int SEW_PAGE_BYTES = 64;
    localparam int SEW_WORD_BYTES = 4;
    localparam int SEW_WORDS = SEW_ARRAY_BYTES / SEW_WORD_BYTES;
    localparam int SEW_PAGE_WORDS = SEW_PAGE_BYTES / SEW_WORD_BYTES;
    localparam int SEW_CHK_BITS = 6;
    localparam int SEW_CODE_BITS = 38;
    localparam logic [7:0] SEW_ERASED_BYTE = 8'h00;
    localparam logic [7:0] SEW_DELIVERY_BYTE = 8'hff;

    // Instruction codes taken from the serial link
    localparam logic [7:0] SEW_OP_SET_WEN = 8'h06;
    localparam logic [7:0] SEW_OP_WRITE = 8'h02;

    // Byte phases of a frame: instruction, address high, address low, data
    localparam logic [1:0] SEW_PH_ADDR_LO = 2'd2;
    localparam logic [1:0] SEW_PH_DATA = 2'd3;

    // Self-timed write cycle
    localparam int SEW_CLK_PERIOD_NS = 20;
    localparam int SEW_WRITE_CYCLE_TIME_NS = 10000000;
    localparam int SEW_TW_CYCLES = SEW_WRITE_CYCLE_TIME_NS / SEW_CLK_PERIOD_NS;

    // Register map, byte addresses
    localparam int SEW_AXI_AW = 8;
    localparam logic [7:0] SEW_REG_STATUS = 8'h00;
    localparam logic [7:0] SEW_REG_CONFIG = 8'h04;
    localparam logic [7:0] SEW_REG_CTRL = 8'h08;
    localparam logic [7:0] SEW_REG_ARR_ADDR = 8'h0c;
    localparam logic [7:0] SEW_REG_ARR_DATA = 8'h10;
    localparam logic [7:0] SEW_REG_ARR_FLIP = 8'h14;

    // Field positions of STATUS, CONFIG and CTRL
    localparam int SEW_SB_WIP = 0;
    localparam int SEW_SB_WEL = 1;
    localparam int SEW_SB_BP_LO = 2;
    localparam int SEW_SB_BP_HI = 3;
    localparam int SEW_SB_STATUS_WRITE_DISABLE = 7;
    localparam int SEW_SB_ARMED = 8;
    localparam int SEW_SB_REJECT = 9;
    localparam int SEW_CTRL_DELIVER = 0;

    // Reset values and bus answers
    localparam logic [12:0] SEW_ARR_ADDR_RST = 13'h0000;
    localparam logic [1:0] SEW_RESP_OKAY = 2'b00;
    localparam logic [1:0] SEW_RESP_DECERR = 2'b11;

    // Write engine states
    typedef enum logic [3:0] {
        SEW_ST_IDLE = 4'b0001,
        SEW_ST_ERASE = 4'b0010,
        SEW_ST_PROG = 4'b0100,
        SEW_ST_WAIT = 4'b1000
    } sew_state_t;

    // Serial pins travel together through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } sew_pins_t;

    localparam sew_pins_t SEW_PINS_IDLE = 3'b100;

    // Hamming check bits over non-power-of-two positions
    function automatic logic [5:0] sew_ecc_chk(input logic [31:0] d);
        logic [5:0] c;
        int k;
        c = 6'h00;
        k = 0;
        for (int j = 1; j <= SEW_CODE_BITS; j++) begin
            if ((j & (j - 1)) != 0) begin
                if (d[k]) c = c ^ 6'(j);
                k++;
            end
        end
        return c;
    endfunction : sew_ecc_chk

    localparam logic [5:0] SEW_ERASED_CHK = sew_ecc_chk({4{SEW_ERASED_BYTE}});
    localparam logic [5:0] SEW_DELIVERY_CHK =
        sew_ecc_chk({4{SEW_DELIVERY_BYTE}});
endpackage : sew_pkg

// >>> hw/sew_ecc_fix.sv
// Single-error correction of one stored word
`timescale 1ns/1ps
`default_nettype none
module sew_ecc_fix
    import sew_pkg::*;
(
    input wire logic [31:0] data_in,
    input wire logic [5:0] chk_in,
    output logic [31:0] data_out
);
    logic [5:0] syndrome;

    // Syndrome naming a data position flips that bit;
    // check-bit hits leave data alone
    always_comb begin
        int k;
        k = 0;
        syndrome = chk_in ^ sew_ecc_chk(data_in);
        data_out = data_in;
        for (int j = 1; j <= SEW_CODE_BITS; j++) begin
            if ((j & (j - 1)) != 0) begin
                if (syndrome == 6'(j)) data_out[k] = ~data_in[k];
                k++;
            end
        end
    end
endmodule : sew_ecc_fix
`default_nettype wire

// >>> hw/sew_array_write.sv
// Serial EEPROM array write engine with AXI4-Lite access
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01 - Host selects, sends instruction, address, data
// RULE_02 - Select rise on byte boundary starts timed write
// RULE_03 - Bytes of one page commit in one cycle
// RULE_04 - In-page address steps, wraps at page end
// RULE_05 - Write refused without enable latch
// RULE_06 - Write refused while a cycle runs
// RULE_07 - Select rise off byte boundary drops write
// RULE_08 - Write refused on protected page
// RULE_09 - Cycle erases to 0, then programs
// RULE_10 - Six check bits per word; single errors fixed
// RULE_11 - Byte write rewrites whole aligned word
// RULE_12 - Host should write aligned four-byte groups
// RULE_13 - Ignore instructions until first select fall
// RULE_14 - Power-up clears enable latch and busy flag
// RULE_15 - Protect and lock bits survive power-up
// RULE_16 - Delivery: array FFh, protect bits zero
// RULE_17 - Status readable, busy shown in cycle
// RULE_18 - Completed write clears enable latch
// RULE_19 - Two address bytes MSB first; 15 bits used
// RULE_20 - Refused write: flag low, array kept
module sew_array_write
    import sew_pkg::*;
#(
    parameter int TW_CYCLES = SEW_TW_CYCLES,
    parameter int AXI_AW = SEW_AXI_AW
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_SI,
    output logic WRITE_BUSY,
    input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    localparam int TW_W = $clog2(TW_CYCLES + 1);
    localparam int PW = $clog2(SEW_PAGE_BYTES);

    sew_pins_t sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;
    logic cs_fall, cs_rise, sclk_rise, byte_done, at_boundary;
    logic [7:0] rx_byte;
    logic [6:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic armed_reg, in_frame_reg;
    logic [7:0] opcode_reg, addr_hi_reg;
    logic [8:0] page_reg;
    logic [PW-1:0] col_reg;
    logic data_take, wen_frame, wr_frame, wr_start, wr_reject, page_locked;
    logic [7:0] buf_reg [SEW_PAGE_BYTES];
    logic [SEW_PAGE_BYTES-1:0] mask_reg;
    sew_state_t state_reg;
    logic [3:0] widx_reg;
    logic [TW_W-1:0] timer_reg;
    logic wip_reg, wel_reg, reject_reg;
    logic status_write_disable_reg, bp_hi_reg, bp_lo_reg;
    logic [31:0] mem_data_reg [SEW_WORDS];
    logic [5:0] mem_chk_reg [SEW_WORDS];
    logic [12:0] cur_word, arr_addr_reg;
    logic word_hit;
    logic [31:0] old_word, new_word, arr_word;
    logic awready_reg, wready_reg, aw_full_reg, w_full_reg, bvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [AXI_AW-1:0] waddr_reg;
    logic [31:0] wdata_reg, wmask, rdata_reg, rd_mux, status_word;
    logic [3:0] wstrb_reg;
    logic arready_reg, rvalid_reg, rd_hit, wr_go, wr_hit;
    logic cfg_wr, ctrl_wr, addr_wr, flip_wr, deliver_go, flip_go;

    // Three-stage synchroniser; stages two and three must agree
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sync1_reg <= SEW_PINS_IDLE;
            sync2_reg <= SEW_PINS_IDLE;
            sync3_reg <= SEW_PINS_IDLE;
            filt_reg <= SEW_PINS_IDLE;
        end else begin
            sync1_reg <= {SPI_CS_N, SPI_SCLK, SPI_SI};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= filt_next;
        end
    end

    // Agreement sets the level, disagreement holds it
    assign filt_next = sew_pins_t'((sync2_reg & sync3_reg)
                                   | (filt_reg & (sync2_reg | sync3_reg)));
    assign cs_fall = filt_reg.cs_n & ~filt_next.cs_n;
    assign cs_rise = ~filt_reg.cs_n & filt_next.cs_n;
    assign sclk_rise = ~filt_reg.sclk & filt_next.sclk & ~filt_next.cs_n;
    assign rx_byte = {shift_reg, filt_next.si};
    assign byte_done = sclk_rise & in_frame_reg & (bit_cnt_reg == 3'd7);
    assign at_boundary = cs_rise & in_frame_reg & (bit_cnt_reg == 3'd0);

    // Frame decoder: instruction, two address bytes MSB first, then data
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            armed_reg <= 1'b0;
            in_frame_reg <= 1'b0;
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 2'd0;
            shift_reg <= 7'h00;
            opcode_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            page_reg <= 9'h000;
            col_reg <= '0;
        end else if (cs_fall) begin
            // A frame already open at reset release shows as a select fall once the synchroniser fills
            armed_reg <= 1'b1; // [RULE_13]
            in_frame_reg <= 1'b1;
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 2'd0;
        end else if (cs_rise) begin
            in_frame_reg <= 1'b0;
        end else if (sclk_rise && in_frame_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            shift_reg <= rx_byte[6:0]; // [RULE_01]
            if (byte_done) begin
                if (byte_cnt_reg != SEW_PH_DATA) begin
                    byte_cnt_reg <= byte_cnt_reg + 2'd1;
                end
                if (byte_cnt_reg == 2'd0) begin
                    opcode_reg <= rx_byte;
                end else if (byte_cnt_reg == 2'd1) begin
                    addr_hi_reg <= rx_byte;
                end else if (byte_cnt_reg == SEW_PH_ADDR_LO) begin
                    // Top address bit is ignored: 15 bits span the array
                    page_reg <= {addr_hi_reg[6:0], rx_byte[7:6]}; // [RULE_19]
                    col_reg <= rx_byte[PW-1:0];
                end else if (data_take) begin
                    col_reg <= col_reg + 1'b1; // [RULE_04]
                end
            end
        end
    end

    assign data_take = byte_done & (byte_cnt_reg == SEW_PH_DATA)
                       & (opcode_reg == SEW_OP_WRITE) & ~wip_reg;

    // Page buffer; erase pass merges untouched old bytes
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mask_reg <= '0;
        end else if (state_reg == SEW_ST_ERASE) begin
            for (int b = 0; b < SEW_WORD_BYTES; b++) begin
                if (!mask_reg[{widx_reg, 2'(b)}]) begin
                    buf_reg[{widx_reg, 2'(b)}] <= old_word[8*b +: 8]; // [RULE_11]
                end
            end
        end else if (!wip_reg) begin
            if (byte_done && byte_cnt_reg == 2'd0) begin
                mask_reg <= '0;
            end
            if (data_take) begin
                buf_reg[col_reg] <= rx_byte; // [RULE_03] [RULE_04]
                mask_reg[col_reg] <= 1'b1;
            end
        end
    end

    // Protected region: upper quarter, upper half or whole array
    always_comb begin
        unique case ({bp_hi_reg, bp_lo_reg})
            2'b00: page_locked = 1'b0;
            2'b01: page_locked = &page_reg[8:7];
            2'b10: page_locked = page_reg[8];
            2'b11: page_locked = 1'b1; // [RULE_08]
        endcase
    end

    // Only a select rise on a byte boundary ends a frame usefully
    assign wen_frame = at_boundary & (opcode_reg == SEW_OP_SET_WEN)
                       & (byte_cnt_reg == 2'd1) & ~wip_reg;
    assign wr_frame = at_boundary & (opcode_reg == SEW_OP_WRITE)
                      & (byte_cnt_reg == SEW_PH_DATA) & (|mask_reg); // [RULE_07]
    assign wr_start = wr_frame & wel_reg & ~wip_reg & ~page_locked; // [RULE_05] [RULE_06] [RULE_08]
    assign wr_reject = cs_rise & in_frame_reg & (opcode_reg == SEW_OP_WRITE)
                       & ~wr_start;

    // Write engine: erase pass, program pass, then wait out the cycle time
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_reg <= SEW_ST_IDLE;
            widx_reg <= 4'd0;
            timer_reg <= '0;
            wip_reg <= 1'b0; // [RULE_14]
            wel_reg <= 1'b0; // [RULE_14]
            reject_reg <= 1'b0;
        end else begin
            if (wen_frame) begin
                wel_reg <= 1'b1;
            end
            // A refused write starts nothing, so the flag stays low
            if (wr_reject) begin
                reject_reg <= 1'b1; // [RULE_20]
            end else if (wr_start) begin
                reject_reg <= 1'b0;
            end
            if (state_reg != SEW_ST_IDLE) begin
                timer_reg <= timer_reg + 1'b1;
            end
            unique case (state_reg)
                SEW_ST_IDLE: begin
                    if (wr_start) begin
                        state_reg <= SEW_ST_ERASE; // [RULE_02]
                        wip_reg <= 1'b1; // [RULE_17]
                        timer_reg <= '0;
                        widx_reg <= 4'd0;
                    end
                end
                SEW_ST_ERASE: begin
                    widx_reg <= widx_reg + 4'd1;
                    if (widx_reg == 4'(SEW_PAGE_WORDS - 1)) begin
                        state_reg <= SEW_ST_PROG; // [RULE_09]
                    end
                end
                SEW_ST_PROG: begin
                    widx_reg <= widx_reg + 4'd1;
                    if (widx_reg == 4'(SEW_PAGE_WORDS - 1)) begin
                        state_reg <= SEW_ST_WAIT;
                    end
                end
                SEW_ST_WAIT: begin
                    if (timer_reg == TW_W'(TW_CYCLES - 1)) begin
                        state_reg <= SEW_ST_IDLE;
                        wip_reg <= 1'b0; // [RULE_02]
                        wel_reg <= 1'b0; // [RULE_18]
                    end
                end
            endcase
        end
    end

    assign WRITE_BUSY = wip_reg;
    assign cur_word = {page_reg, widx_reg};
    assign word_hit = |mask_reg[{widx_reg, 2'b00} +: SEW_WORD_BYTES];

    // Merged word leaves the buffer in address order, low byte first
    always_comb begin
        for (int b = 0; b < SEW_WORD_BYTES; b++) begin
            new_word[8*b +: 8] = buf_reg[{widx_reg, 2'(b)}];
        end
    end

    // Corrected reads for the erase merge and for software
    sew_ecc_fix u_fix_merge (
        .data_in(mem_data_reg[cur_word]),
        .chk_in(mem_chk_reg[cur_word]),
        .data_out(old_word)
    );
    sew_ecc_fix u_fix_read (
        .data_in(mem_data_reg[arr_addr_reg]),
        .chk_in(mem_chk_reg[arr_addr_reg]),
        .data_out(arr_word) // [RULE_10]
    );

    // Non-volatile cells: reset leaves them alone
    always_ff @(posedge CLK_SYS) begin
        if (deliver_go) begin
            for (int i = 0; i < SEW_WORDS; i++) begin
                mem_data_reg[i] <= {4{SEW_DELIVERY_BYTE}}; // [RULE_16]
                mem_chk_reg[i] <= SEW_DELIVERY_CHK;
            end
        end else if (state_reg == SEW_ST_ERASE && word_hit) begin
            mem_data_reg[cur_word] <= {4{SEW_ERASED_BYTE}}; // [RULE_09]
            mem_chk_reg[cur_word] <= SEW_ERASED_CHK;
        end else if (state_reg == SEW_ST_PROG && word_hit) begin
            mem_data_reg[cur_word] <= new_word; // [RULE_09] [RULE_11]
            mem_chk_reg[cur_word] <= sew_ecc_chk(new_word); // [RULE_10]
        end else if (flip_go) begin
            // Lets software plant a bit error without fixing the check bits
            mem_data_reg[arr_addr_reg] <= mem_data_reg[arr_addr_reg]
                                          ^ (wdata_reg & wmask);
        end
    end

    // Protect and lock bits survive the system reset
    always_ff @(posedge CLK_SYS) begin
        if (deliver_go) begin
            status_write_disable_reg <= 1'b0; // [RULE_16]
            bp_hi_reg <= 1'b0;
            bp_lo_reg <= 1'b0;
        end else if (cfg_wr && wstrb_reg[0]) begin
            status_write_disable_reg <= wdata_reg[SEW_SB_STATUS_WRITE_DISABLE]; // [RULE_15]
            bp_hi_reg <= wdata_reg[SEW_SB_BP_HI];
            bp_lo_reg <= wdata_reg[SEW_SB_BP_LO];
        end
    end

    // Write decode once address and data are held
    assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign cfg_wr = wr_go & (waddr_reg == SEW_REG_CONFIG);
    assign ctrl_wr = wr_go & (waddr_reg == SEW_REG_CTRL);
    assign addr_wr = wr_go & (waddr_reg == SEW_REG_ARR_ADDR);
    assign flip_wr = wr_go & (waddr_reg == SEW_REG_ARR_FLIP);
    // Delivery and bit flips are dropped while a cycle runs rather than corrupt it
    assign deliver_go = ctrl_wr & wstrb_reg[0] & ~wip_reg
                        & wdata_reg[SEW_CTRL_DELIVER];
    assign flip_go = flip_wr & ~wip_reg;
    assign wr_hit = cfg_wr | ctrl_wr | addr_wr | flip_wr
                    | (waddr_reg == SEW_REG_STATUS)
                    | (waddr_reg == SEW_REG_ARR_DATA);

    // Word pointer for array reads and error planting
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            arr_addr_reg <= SEW_ARR_ADDR_RST;
        end else if (addr_wr) begin
            arr_addr_reg <= (arr_addr_reg & ~wmask[12:0])
                            | (wdata_reg[12:0] & wmask[12:0]);
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= SEW_RESP_OKAY;
            waddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            awready_reg <= S_AXI_AWVALID & ~awready_reg & ~aw_full_reg;
            wready_reg <= S_AXI_WVALID & ~wready_reg & ~w_full_reg;
            if (S_AXI_AWVALID && awready_reg) begin
                aw_full_reg <= 1'b1;
                waddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && wready_reg) begin
                w_full_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? SEW_RESP_OKAY : SEW_RESP_DECERR;
            end else if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Status stays readable while a write cycle runs
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[SEW_SB_WIP] = wip_reg; // [RULE_17]
        status_word[SEW_SB_WEL] = wel_reg;
        status_word[SEW_SB_BP_LO] = bp_lo_reg;
        status_word[SEW_SB_BP_HI] = bp_hi_reg;
        status_word[SEW_SB_STATUS_WRITE_DISABLE] = status_write_disable_reg;
        status_word[SEW_SB_ARMED] = armed_reg;
        status_word[SEW_SB_REJECT] = reject_reg;
    end

    // Read mux; write-only registers read as zero
    always_comb begin
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            SEW_REG_STATUS: rd_mux = status_word;
            SEW_REG_CONFIG: rd_mux = status_word & 32'h0000_008c;
            SEW_REG_ARR_ADDR: rd_mux = {19'h00000, arr_addr_reg};
            SEW_REG_ARR_DATA: rd_mux = arr_word;
            SEW_REG_CTRL, SEW_REG_ARR_FLIP: rd_mux = 32'h0000_0000;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read under way at a time
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= SEW_RESP_OKAY;
        end else begin
            arready_reg <= S_AXI_ARVALID & ~arready_reg & ~rvalid_reg;
            if (S_AXI_ARVALID && arready_reg) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? SEW_RESP_OKAY : SEW_RESP_DECERR;
            end else if (rvalid_reg && S_AXI_RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
endmodule : sew_array_write
`default_nettype wire

// >>> verification/sew_write_properties.sv
// Write-cycle timing and bus answer checks
`timescale 1ns/1ps
`default_nettype none
module sew_write_properties #(
    parameter int TW_CYCLES = 64
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic SPI_CS_N,
    input wire logic WRITE_BUSY,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA
);
    int cnt_reg;
    // Length of the running busy period, cleared while idle or in reset
    always_ff @(posedge CLK_SYS) begin
        cnt_reg <= (SRST || !WRITE_BUSY) ? 0 : cnt_reg + 1;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    a_busy_start: assert property ($rose(WRITE_BUSY) |-> SPI_CS_N)
        else $error("busy rose while selected");
    a_busy_len: assert property ($fell(WRITE_BUSY) |-> cnt_reg == TW_CYCLES)
        else $error("write cycle length wrong");
    a_busy_max: assert property (WRITE_BUSY |-> cnt_reg < TW_CYCLES)
        else $error("write cycle overran");
    a_sel_quiet: assert property (!SPI_CS_N [*6] |=> !$rose(WRITE_BUSY))
        else $error("write started without deselect");
    a_aw_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("address ready held");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    a_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write answer repeated");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer changed");
endmodule : sew_write_properties
bind sew_array_write sew_write_properties #(.TW_CYCLES(TW_CYCLES)) i_props (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .SPI_CS_N(SPI_CS_N),
    .WRITE_BUSY(WRITE_BUSY), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .S_AXI_RDATA(S_AXI_RDATA));
`default_nettype wire

// >>> verification/sew_spi_host.sv
// Serial host model sending framed bytes
`timescale 1ns/1ps
`default_nettype none
module sew_spi_host (
    output logic cs_n,
    output logic sclk,
    output logic si
);
    // Idle: deselected, clock low
    initial {cs_n, sclk, si} = 3'b100;
    // Data set up half a period early
    task automatic put_bit(input logic v);
        si = v;
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
    endtask : put_bit
    // Stray bits break the byte boundary; deselect lasts a bit time
    task automatic frame(input logic [7:0] b[$], input int stray);
        #160 cs_n = 1'b0;
        #80;
        foreach (b[i]) for (int k = 7; k >= 0; k--) put_bit(b[i][k]);
        for (int k = 0; k < stray; k++) put_bit(1'b1);
        #80 cs_n = 1'b1;
        si = ~si;
    endtask : frame
endmodule : sew_spi_host
`default_nettype wire

// >>> verification/testbench.sv
// Bench of the serial array write block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sew_pkg::*;
    localparam int TW = 400;
    logic clk = 1'b0, srst = 1'b1, cs_n, sclk, si, busy, awr, wr, bv, arr, rv;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [1:0] bresp, rresp, rsp;
    int failures = 0, checks_done = 0, cycles = 0;
    sew_array_write #(.TW_CYCLES(TW)) i_sew_array_write (
        .CLK_SYS(clk), .SRST(srst), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
        .SPI_SI(si), .WRITE_BUSY(busy), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rready));
    sew_spi_host i_sew_spi_host (.cs_n(cs_n), .sclk(sclk), .si(si));
    always #10 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // AW and W together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'b111};
        repeat (20) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        {araddr, arv, rready} <= {a, 2'b11};
        repeat (20) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        {rd, rsp} = {rdata, rresp};
        rready <= 1'b0;
    endtask : axr
    task automatic wait_busy(input logic v);
        repeat (TW + 20) begin
            @(posedge clk);
            if (busy === v) break;
        end
        chk({31'h0, busy}, {31'h0, v});
    endtask : wait_busy
    // Refused frames start no cycle
    task automatic quiet();
        repeat (20) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
    endtask : quiet
    task automatic t_idle();
        axw(SEW_REG_CTRL, 32'h1);
        axr(SEW_REG_STATUS);
        chk(rd & 32'h18f, 32'h0);
        axr(SEW_REG_ARR_DATA);
        chk(rd, 32'hffffffff);
        axr(8'h40);
        chk({30'h0, rsp}, {30'h0, SEW_RESP_DECERR});
        $display("t_idle done");
    endtask : t_idle
    task automatic t_refuse();
        i_sew_spi_host.frame('{8'h02, 8'h00, 8'h08, 8'h5a}, 0);
        quiet();
        axr(SEW_REG_STATUS);
        chk(rd & 32'h303, 32'h300);
        i_sew_spi_host.frame('{8'h06}, 0);
        i_sew_spi_host.frame('{8'h02, 8'h00, 8'h08, 8'h44}, 3);
        quiet();
        axw(SEW_REG_CONFIG, 32'h0c);
        i_sew_spi_host.frame('{8'h02, 8'h00, 8'h08, 8'h66}, 0);
        quiet();
        axr(SEW_REG_CONFIG);
        chk(rd & 32'h8c, 32'h0c);
        axw(SEW_REG_CONFIG, 32'h0);
        axw(SEW_REG_ARR_ADDR, 32'h2);
        axr(SEW_REG_ARR_DATA);
        chk(rd, 32'hffffffff);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_page();
        i_sew_spi_host.frame('{8'h02, 8'h80, 8'h3e, 8'h11, 8'h22, 8'h33}, 0);
        wait_busy(1'b1);
        axr(SEW_REG_STATUS);
        chk(rd & 32'h3, 32'h3);
        i_sew_spi_host.frame('{8'h02, 8'h00, 8'h04, 8'h77}, 0);
        wait_busy(1'b0);
        quiet();
        axr(SEW_REG_STATUS);
        chk(rd & 32'h3, 32'h0);
        axw(SEW_REG_ARR_ADDR, 32'hf);
        axr(SEW_REG_ARR_DATA);
        chk(rd, 32'h2211ffff);
        axw(SEW_REG_ARR_ADDR, 32'h1);
        axr(SEW_REG_ARR_DATA);
        chk(rd, 32'hffffffff);
        axw(SEW_REG_ARR_ADDR, 32'h0);
        axw(SEW_REG_ARR_FLIP, 32'h100);
        axr(SEW_REG_ARR_DATA);
        chk(rd, 32'hffffff33);
        $display("t_page done");
    endtask : t_page
    task automatic report_and_stop();
        $display("Checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_idle();
        t_refuse();
        i_sew_spi_host.frame('{8'h06}, 0);
        t_page();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
